// ### hw/iommu_pkg.sv
package iommu_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          IDX_W           = 4;     // wrap bit plus three slot bits
  localparam int          SLOT_SHIFT      = 3;     // each queue or table entry is 8 bytes
  // register byte offsets
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_STATUS      = 8'h04;
  localparam logic [7:0]  OFF_CMDQ_BASE   = 8'h08;
  localparam logic [7:0]  OFF_CMDQ_WRITER = 8'h0C;
  localparam logic [7:0]  OFF_CMDQ_READER = 8'h10;
  localparam logic [7:0]  OFF_STREAM_TABLE_BASE = 8'h14;
  localparam logic [7:0]  OFF_STRTAB_SIZE = 8'h18;
  localparam logic [7:0]  OFF_EVTQ_BASE   = 8'h1C;
  localparam logic [7:0]  OFF_EVTQ_WRITER = 8'h20;
  localparam logic [7:0]  OFF_EVTQ_READER = 8'h24;
  // control and status bit positions
  localparam int          CTRL_GLOB       = 0;
  localparam int          CTRL_CMDQ       = 1;
  localparam int          CTRL_EVTQ       = 2;
  localparam int          ST_CMD_ERR      = 2;
  localparam int          ST_EVT_OVF      = 3;
  localparam int          ST_WALK_BUSY    = 4;
  localparam logic [1:0]  BREAK_BEFORE_MAKE_LEVEL_LEVEL      = 2'h2;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;
  // in-memory entry fields
  localparam int          ENT_VALID       = 0;
  localparam int          STE_S1          = 1;
  localparam int          CD_RSVD         = 1;
  localparam int          STE_LIMIT_LSB   = 4;
  localparam int          PTR_LSB         = 32;
  localparam logic [7:0]  CMD_OP_ILLEGAL  = 8'h00;
  localparam int          BLOCK_SPLIT     = 9;     // page bits inside one block
  // walk fault codes and read kinds
  localparam logic [2:0]  FLT_NONE        = 3'h0;
  localparam logic [2:0]  FLT_RANGE       = 3'h1;
  localparam logic [2:0]  FLT_STE         = 3'h2;
  localparam logic [2:0]  FLT_CD          = 3'h3;
  localparam logic [2:0]  FLT_DISABLED    = 3'h4;
  localparam logic [1:0]  KIND_CMD        = 2'h0;
  localparam logic [1:0]  KIND_STE        = 2'h1;
  localparam logic [1:0]  KIND_CD         = 2'h2;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_CMD = 3'b001, M_STE = 3'b010, M_CD = 3'b011, M_EVT = 3'b100
  } mem_state_t;

  typedef struct packed {
    logic        valid;
    logic        block;
    logic [19:0] vpn;
    logic [19:0] ppn;
  } tlb_entry_t;

  typedef struct packed {
    logic                  aw_got;
    logic [ADDR_W-1:0]     aw_addr;
    logic                  w_got;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  glob_en;
    logic                  cmdq_en;
    logic                  evtq_en;
    logic [31:0]           cmdq_base;
    logic [IDX_W-1:0]      cmd_writer;
    logic [IDX_W-1:0]      cmd_reader;
    logic                  cmd_error;
    logic [31:0]           stream_table_base;
    logic [15:0]           strtab_size;
    logic [31:0]           evtq_base;
    logic [IDX_W-1:0]      evt_writer;
    logic [IDX_W-1:0]      evt_reader;
    logic                  evt_overflow;
    logic                  evt_pend;
    logic [63:0]           evt_rec;
    mem_state_t            mst;
    logic [31:0]           mem_addr;
    logic                  cbuf_valid;
    logic [63:0]           cbuf;
    logic                  walk_busy;
    logic                  walk_cd;
    logic [7:0]            walk_stream;
    logic [7:0]            walk_sub;
    logic [63:0]           stream_entry;
    logic                  walk_done;
    logic                  walk_ok;
    logic [63:0]           walk_ctx;
    logic [2:0]            walk_fault;
    tlb_entry_t [3:0]      tlb;
    logic [1:0]            fill_ptr;
    logic                  look_done;
    logic                  look_hit;
    logic [19:0]           look_pa;
  } state_t;
endpackage : iommu_pkg

// ### hw/iommu_queue_and_config_fetch.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - at level 2 the cache-suppress bit is ignored; size changes need no invalidate first.
// - size change of a valid translation never raises a multi-hit fault.
// - a multi-match lookup translates from one matching entry only.
// - multi-match lookups raise no fault impossible under old or new descriptor.
// - output never merges entries, old and new states, or invented data.
// - invalidation removes every matching entry, overlaps included.
// - toggling the contiguous hint never gives a multi-hit fault.
// - device never writes the command queue; only event queue writes.
// - commands become eligible only through the writer index register.
// - device may read ahead occupied slots without coherency to processor caches.
// - command error or queue disable discards every buffered command.
// - each buffered command runs once; stale copies never replace reused slots.
// - writer index updated consistently unless disabled or in error.
// - an entry is valid only with valid flag 1 and no illegal field mix.
// - pointers inside invalid structures are never followed.
// - with global enable 0 no stream fetch and no cache insertion.
// - context descriptors are fetched only via a valid stage-1 stream entry.
// - stream entries are fetched only inside the configured table bounds.
// - context descriptors are fetched only within the stream entry's size limit.
// - unreachable structures are never fetched; a walk stops at the first invalid one.
module iommu_queue_and_config_fetch
  import iommu_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  output      logic              mem_rd_valid,
  output      logic [31:0]       mem_rd_addr,
  output      logic [1:0]        mem_rd_kind,
  input  wire logic              mem_rd_done,
  input  wire logic [63:0]       mem_rd_data,
  output      logic              mem_wr_valid,
  output      logic [31:0]       mem_wr_addr,
  output      logic [63:0]       mem_wr_data,
  input  wire logic              mem_wr_done,
  output      logic              cmd_valid,
  output      logic [63:0]       cmd_data,
  input  wire logic              cmd_ready,
  input  wire logic              walk_req,
  input  wire logic [7:0]        walk_stream,
  input  wire logic [7:0]        walk_sub,
  output      logic              walk_ready,
  output      logic              walk_done,
  output      logic              walk_ok,
  output      logic [63:0]       walk_ctx,
  output      logic [2:0]        walk_fault,
  input  wire logic              fill_valid,
  input  wire logic [19:0]       fill_va,
  input  wire logic [19:0]       fill_pa,
  input  wire logic              fill_block,
  input  wire logic              block_cache_suppress,
  input  wire logic              inv_valid,
  input  wire logic [19:0]       inv_va,
  input  wire logic              lookup_valid,
  input  wire logic [19:0]       lookup_va,
  output      logic              look_done,
  output      logic              look_hit,
  output      logic [19:0]       look_pa
);

  state_t     state;
  state_t     next_state;
  logic [3:0] hit_vec;
  logic [3:0] inv_vec;

  // entry covers a page number: blocks compare only the upper bits
  function automatic logic covers(tlb_entry_t e, logic [19:0] va);
    covers = e.valid && (e.block ? (e.vpn[19:BLOCK_SPLIT] == va[19:BLOCK_SPLIT])
                                 : (e.vpn == va));
  endfunction : covers

  function automatic logic addr_known(logic [ADDR_W-1:0] a);
    addr_known = (a[1:0] == 2'h0) && (a <= OFF_EVTQ_READER);
  endfunction : addr_known

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] be);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        merge[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction : merge

  function automatic logic [31:0] reg_word(state_t st, logic [ADDR_W-1:0] a);
    reg_word = 32'h0;
    case (a)
      OFF_CTRL:        reg_word[2:0] = {st.evtq_en, st.cmdq_en, st.glob_en};
      OFF_STATUS:      reg_word[4:0] = {st.walk_busy, st.evt_overflow, st.cmd_error, BREAK_BEFORE_MAKE_LEVEL_LEVEL};
      OFF_CMDQ_BASE:   reg_word = st.cmdq_base;
      OFF_CMDQ_WRITER: reg_word[IDX_W-1:0] = st.cmd_writer;
      OFF_CMDQ_READER: reg_word[IDX_W-1:0] = st.cmd_reader;
      OFF_STREAM_TABLE_BASE: reg_word = st.stream_table_base;
      OFF_STRTAB_SIZE: reg_word[15:0] = st.strtab_size;
      OFF_EVTQ_BASE:   reg_word = st.evtq_base;
      OFF_EVTQ_WRITER: reg_word[IDX_W-1:0] = st.evt_writer;
      OFF_EVTQ_READER: reg_word[IDX_W-1:0] = st.evt_reader;
      default:         reg_word = 32'h0;
    endcase
  endfunction : reg_word

  // closes a walk and queues an event record for real faults
  function automatic state_t finish(state_t st, logic [2:0] code, logic [63:0] ctx);
    finish = st;
    finish.walk_done  = 1'b1;
    finish.walk_busy  = 1'b0;
    finish.walk_cd    = 1'b0;
    finish.walk_ok    = (code == FLT_NONE);
    finish.walk_fault = code;
    finish.walk_ctx   = ctx;
    if (code != FLT_NONE && code != FLT_DISABLED && st.evtq_en) begin
      if (st.evt_pend) begin
        finish.evt_overflow = 1'b1;
      end else begin
        finish.evt_pend = 1'b1;
        finish.evt_rec  = {45'h0, code, st.walk_stream, st.walk_sub};
      end
    end
  endfunction : finish

  // match vectors for lookup and invalidation
  for (genvar i = 0; i < 4; i++) begin : g_match
    assign hit_vec[i] = covers(state.tlb[i], lookup_va);
    assign inv_vec[i] = covers(state.tlb[i], inv_va);
  end

  // bus handshakes: one write and one read in flight
  assign awready      = !state.aw_got && !state.bvalid;
  assign wready       = !state.w_got && !state.bvalid;
  assign arready      = !state.rvalid;
  assign bvalid       = state.bvalid;
  assign bresp        = state.bresp;
  assign rvalid       = state.rvalid;
  assign rdata        = state.rdata;
  assign rresp        = state.rresp;
  assign mem_rd_valid = (state.mst == M_CMD) || (state.mst == M_STE) || (state.mst == M_CD);
  assign mem_rd_addr  = state.mem_addr;
  assign mem_rd_kind  = (state.mst == M_STE) ? KIND_STE : (state.mst == M_CD) ? KIND_CD : KIND_CMD;
  assign mem_wr_valid = (state.mst == M_EVT);
  assign mem_wr_addr  = state.mem_addr;
  assign mem_wr_data  = state.evt_rec;
  assign cmd_valid    = state.cbuf_valid;
  assign cmd_data     = state.cbuf;
  assign walk_ready   = !state.walk_busy;
  assign walk_done    = state.walk_done;
  assign walk_ok      = state.walk_ok;
  assign walk_ctx     = state.walk_ctx;
  assign walk_fault   = state.walk_fault;
  assign look_done    = state.look_done;
  assign look_hit     = state.look_hit;
  assign look_pa      = state.look_pa;

  always_comb begin
    logic [31:0] wv;
    logic        evt_full;
    logic [15:0] limit;
    next_state           = state;
    next_state.walk_done = 1'b0;
    next_state.look_done = 1'b0;
    wv                   = merge(reg_word(state, state.aw_addr), state.w_data, state.w_strb);
    evt_full = (state.evt_writer[IDX_W-2:0] == state.evt_reader[IDX_W-2:0]) &&
               (state.evt_writer[IDX_W-1] != state.evt_reader[IDX_W-1]);
    limit    = {8'h0, state.stream_entry[STE_LIMIT_LSB +: 8]};
    // register writes, taken once address and data are both held
    if (awvalid && awready) begin
      next_state.aw_got  = 1'b1;
      next_state.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_state.w_got  = 1'b1;
      next_state.w_data = wdata;
      next_state.w_strb = wstrb;
    end
    if (state.bvalid && bready) begin
      next_state.bvalid = 1'b0;
    end
    if (state.aw_got && state.w_got && !state.bvalid) begin
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp  = addr_known(state.aw_addr) ? RESP_OKAY : RESP_DECERR;
      case (state.aw_addr)
        OFF_CTRL: begin
          next_state.glob_en = wv[CTRL_GLOB];
          next_state.cmdq_en = wv[CTRL_CMDQ];
          next_state.evtq_en = wv[CTRL_EVTQ];
          if (!wv[CTRL_CMDQ]) begin
            next_state.cmd_error  = 1'b0;
            next_state.cbuf_valid = 1'b0;
          end
        end
        OFF_CMDQ_BASE:   next_state.cmdq_base   = wv;
        OFF_CMDQ_WRITER: next_state.cmd_writer  = wv[IDX_W-1:0];
        OFF_CMDQ_READER: if (!state.cmdq_en) next_state.cmd_reader = wv[IDX_W-1:0];
        OFF_STREAM_TABLE_BASE: next_state.stream_table_base = wv;
        OFF_STRTAB_SIZE: next_state.strtab_size = wv[15:0];
        OFF_EVTQ_BASE:   next_state.evtq_base   = wv;
        OFF_EVTQ_READER: next_state.evt_reader  = wv[IDX_W-1:0];
        default:         next_state.bvalid      = 1'b1;
      endcase
    end
    // register reads answer one edge after the address is taken
    if (state.rvalid && rready) begin
      next_state.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = reg_word(state, araddr);
      next_state.rresp  = addr_known(araddr) ? RESP_OKAY : RESP_DECERR;
    end
    // consumer takes the buffered command; slot freed with wrap
    if (state.cbuf_valid && cmd_ready) begin
      next_state.cbuf_valid = 1'b0;
      next_state.cmd_reader = state.cmd_reader + 1'b1;
    end
    if (walk_req && !state.walk_busy) begin
      next_state.walk_busy   = 1'b1;
      next_state.walk_stream = walk_stream;
      next_state.walk_sub    = walk_sub;
    end
    // memory engine: one access at a time, event writes first
    case (state.mst)
      M_IDLE: begin
        if (state.evt_pend && state.evtq_en && !evt_full) begin
          next_state.mst      = M_EVT;
          next_state.mem_addr = state.evtq_base + {state.evt_writer[IDX_W-2:0], 3'h0};
        end else if (state.walk_busy && !state.glob_en) begin
          next_state = finish(next_state, FLT_DISABLED, 64'h0);
        end else if (state.walk_busy && !state.walk_cd) begin
          if ({8'h0, state.walk_stream} >= state.strtab_size) begin
            next_state = finish(next_state, FLT_RANGE, 64'h0);
          end else begin
            next_state.mst      = M_STE;
            next_state.mem_addr = state.stream_table_base + {21'h0, state.walk_stream, 3'h0};
          end
        end else if (state.walk_busy) begin
          if ({8'h0, state.walk_sub} > limit) begin
            next_state = finish(next_state, FLT_RANGE, 64'h0);
          end else begin
            next_state.mst      = M_CD;
            next_state.mem_addr = state.stream_entry[PTR_LSB +: 32] + {21'h0, state.walk_sub, 3'h0};
          end
        end else if (state.cmdq_en && !state.cmd_error && !state.cbuf_valid &&
                     state.cmd_writer != state.cmd_reader) begin
          next_state.mst      = M_CMD;
          next_state.mem_addr = state.cmdq_base + {state.cmd_reader[IDX_W-2:0], 3'h0};
        end
      end
      M_CMD: if (mem_rd_done) begin
        next_state.mst = M_IDLE;
        if (next_state.cmdq_en && !state.cmd_error) begin
          if (mem_rd_data[7:0] == CMD_OP_ILLEGAL) begin
            next_state.cmd_error = 1'b1;
          end else begin
            next_state.cbuf_valid = 1'b1;
            next_state.cbuf       = mem_rd_data;
          end
        end
      end
      M_STE: if (mem_rd_done) begin
        next_state.mst = M_IDLE;
        next_state.stream_entry = mem_rd_data;
        if (!mem_rd_data[ENT_VALID] ||
            (mem_rd_data[STE_S1] && mem_rd_data[PTR_LSB +: 32] == 32'h0)) begin
          next_state = finish(next_state, FLT_STE, 64'h0);
        end else if (!mem_rd_data[STE_S1]) begin
          next_state = finish(next_state, FLT_NONE, 64'h0);
        end else begin
          next_state.walk_cd = 1'b1;
        end
      end
      M_CD: if (mem_rd_done) begin
        next_state.mst = M_IDLE;
        if (!mem_rd_data[ENT_VALID] || mem_rd_data[CD_RSVD]) begin
          next_state = finish(next_state, FLT_CD, 64'h0);
        end else begin
          next_state = finish(next_state, FLT_NONE, mem_rd_data);
        end
      end
      M_EVT: if (mem_wr_done) begin
        next_state.mst        = M_IDLE;
        next_state.evt_pend   = 1'b0;
        next_state.evt_writer = state.evt_writer + 1'b1;
      end
      default: next_state.mst = M_IDLE;
    endcase
    // lookup: lowest matching slot wins, no conflict fault exists
    if (lookup_valid) begin
      next_state.look_done = 1'b1;
      next_state.look_hit  = (hit_vec != 4'h0) && state.glob_en;
      next_state.look_pa   = 20'h0;
      for (int i = 3; i >= 0; i--) begin
        if (hit_vec[i]) begin
          next_state.look_pa = state.tlb[i].block ?
            {state.tlb[i].ppn[19:BLOCK_SPLIT], lookup_va[BLOCK_SPLIT-1:0]} :
            state.tlb[i].ppn;
        end
      end
    end
    // invalidate clears every overlapping match
    for (int i = 0; i < 4; i++) begin
      if (inv_valid && inv_vec[i]) begin
        next_state.tlb[i].valid = 1'b0;
      end
    end
    // fills never probe for overlaps; suppress and contiguous hints unused
    if (fill_valid && state.glob_en) begin
      next_state.tlb[state.fill_ptr] = '{valid: 1'b1, block: fill_block,
                                         vpn: fill_va, ppn: fill_pa};
      next_state.fill_ptr = state.fill_ptr + 1'b1;
    end
  end

  // all state in one register; sync reset to zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_write_only_events: assert property (mem_wr_valid |->
    mem_wr_addr == state.evtq_base + {state.evt_writer[IDX_W-2:0], 3'h0})
    else $error("write outside event queue slot");
  a_fetch_needs_writer: assert property ((state.mst == M_IDLE && $past(state.mst) == M_IDLE
    && state.cmd_writer == state.cmd_reader) |=> state.mst != M_CMD)
    else $error("command fetched with empty queue");
  a_disable_drops_cmd: assert property ($fell(state.cmdq_en) |-> !cmd_valid)
    else $error("buffered command kept after disable");
  a_reader_wraps: assert property (cmd_valid && cmd_ready |=>
    state.cmd_reader == $past(state.cmd_reader) + 4'h1)
    else $error("reader index did not advance");
  a_consume_once: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
    else $error("command offered twice");
  a_no_fetch_disabled: assert property (mem_rd_valid && mem_rd_kind == KIND_STE
    && $rose(mem_rd_valid) |-> $past(state.glob_en))
    else $error("stream fetch while disabled");
  a_cd_needs_ste: assert property (mem_rd_valid && mem_rd_kind == KIND_CD |->
    state.stream_entry[ENT_VALID] && state.stream_entry[STE_S1])
    else $error("context fetch without valid stage-1 entry");
  a_ste_bounds: assert property (mem_rd_valid && mem_rd_kind == KIND_STE |->
    {8'h0, state.walk_stream} < state.strtab_size)
    else $error("stream fetch out of bounds");
  a_inval_clears: assert property (inv_valid && !fill_valid ##1 lookup_valid
    && lookup_va == $past(inv_va) |=> !look_hit)
    else $error("stale entry survived invalidation");
  a_lookup_done: assert property (lookup_valid |=> look_done ##1 !$past(lookup_valid)
    || look_done)
    else $error("lookup not answered next cycle");

  c_cmd_consumed: cover property (cmd_valid && cmd_ready);
  c_walk_ok:      cover property (walk_done && walk_ok && walk_ctx != 64'h0);
  c_multi_hit:    cover property (lookup_valid && hit_vec != 4'h0 &&
                                  (hit_vec & (hit_vec - 4'h1)) != 4'h0);
  c_event_write:  cover property (mem_wr_valid && mem_wr_done);

endmodule : iommu_queue_and_config_fetch

// ### tb/mem_model.sv
`timescale 1ns/10ps
module mem_model #(parameter int DLY = 2) (
  input  wire logic        sys_clk,
  input  wire logic        mem_rd_valid,
  input  wire logic [31:0] mem_rd_addr,
  output      logic        mem_rd_done,
  output      logic [63:0] mem_rd_data,
  input  wire logic        mem_wr_valid,
  input  wire logic [31:0] mem_wr_addr,
  input  wire logic [63:0] mem_wr_data,
  output      logic        mem_wr_done
);
  logic [63:0] mem [256];
  int          cnt = 0;
  int          nrd = 0;
  int          ncw = 0;
  initial {mem_rd_done, mem_wr_done, mem_rd_data} = '0;
  // slow answer; idle data lines flip so a stale word never passes for fresh
  always @(posedge sys_clk) begin
    mem_rd_done <= 1'b0;
    mem_wr_done <= 1'b0;
    mem_rd_data <= ~mem_rd_data;
    if ((mem_rd_valid || mem_wr_valid) && !mem_rd_done && !mem_wr_done) begin
      cnt <= (cnt >= DLY) ? 0 : cnt + 1;
      if (cnt >= DLY && mem_rd_valid) begin
        mem_rd_done <= 1'b1;
        mem_rd_data <= mem[mem_rd_addr[10:3]];
        nrd <= nrd + 1;
      end else if (cnt >= DLY) begin
        mem_wr_done <= 1'b1;
        mem[mem_wr_addr[10:3]] <= mem_wr_data;
        ncw <= ncw + int'(mem_wr_addr < 32'h40);
      end
    end
  end
endmodule : mem_model

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  import iommu_pkg::*;
  logic sys_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic walk_req = 0, fill_valid = 0, fill_block = 0, inv_valid = 0, lookup_valid = 0;
  logic cmd_ready = 1, block_cache_suppress = 1, cmd_valid, walk_ready, walk_done, walk_ok;
  logic awready, wready, bvalid, arready, rvalid, mem_rd_valid, mem_rd_done, mem_wr_valid;
  logic mem_wr_done, look_done, look_hit;
  logic [1:0]  bresp, rresp, mem_rd_kind;
  logic [2:0]  walk_fault;
  logic [3:0]  wstrb = 4'hF;
  logic [7:0]  awaddr = 0, araddr = 0, walk_stream = 0, walk_sub = 0;
  logic [19:0] fill_va = 0, fill_pa = 0, inv_va = 0, lookup_va = 0, look_pa;
  logic [31:0] wdata = 0, rdata, mem_rd_addr, mem_wr_addr, d;
  logic [63:0] mem_rd_data, mem_wr_data, cmd_data, walk_ctx;
  int          fails = 0, tests_run = 0, n;
  iommu_queue_and_config_fetch iommu_queue_and_config_fetch_inst (.*);
  mem_model #(.DLY(2)) mem_model_inst (.*);
  initial forever #20 sys_clk = ~sys_clk;
  task chk(input logic [63:0] g, e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // bus master: hold each channel until its own ready
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    fork
      begin do @(posedge sys_clk); while (!awready); awvalid <= 0; end
      begin do @(posedge sys_clk); while (!wready); wvalid <= 0; end
    join
    while (!bvalid) @(posedge sys_clk);
    bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [1:0] r);
    @(posedge sys_clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge sys_clk); while (!arready);
    arvalid <= 0;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 0;
    d = rdata;
    chk(rresp, r);
  endtask : rd
  task walk(input logic [7:0] s, u, input logic [2:0] f, input logic [63:0] c);
    @(posedge sys_clk);
    {walk_req, walk_stream, walk_sub} <= {1'b1, s, u};
    @(posedge sys_clk);
    chk(walk_ready, 1'b1);
    walk_req <= 0;
    do @(posedge sys_clk); while (!walk_done);
    chk(walk_fault, f);
    chk(walk_ok, f == FLT_NONE);
    chk(walk_ctx, c);
  endtask : walk
  task look(input logic [19:0] va, input logic h, input logic [19:0] pa);
    @(posedge sys_clk);
    {lookup_valid, lookup_va} <= {1'b1, va};
    @(posedge sys_clk);
    lookup_valid <= 0;
    do @(posedge sys_clk); while (!look_done);
    chk(look_hit, h);
    if (h) chk(look_pa, pa);
  endtask : look
  task t_cmdq;
    mem_model_inst.mem[0] = 64'h11;
    mem_model_inst.mem[1] = 64'h22;
    mem_model_inst.mem[2] = 64'h0; // illegal opcode
    wr(OFF_CMDQ_BASE, 32'h0);
    wr(OFF_CTRL, 32'h3);
    repeat (6) @(posedge sys_clk);
    chk(mem_model_inst.nrd, 0);
    wr(OFF_CMDQ_WRITER, 32'h2);
    do @(posedge sys_clk); while (!cmd_valid);
    chk(cmd_data, 64'h11);
    do @(posedge sys_clk); while (!cmd_valid);
    chk(cmd_data, 64'h22);
    repeat (8) @(posedge sys_clk);
    rd(OFF_CMDQ_READER, RESP_OKAY);
    chk(d, 32'h2);
    chk(mem_model_inst.nrd, 2);
    wr(OFF_CMDQ_WRITER, 32'h3);
    repeat (10) @(posedge sys_clk);
    rd(OFF_STATUS, RESP_OKAY);
    chk(d, 32'h6);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_STATUS, RESP_OKAY);
    chk(d, 32'h2);
    chk(mem_model_inst.ncw, 0);
    // hold the consumer off so a fetched command stays buffered
    cmd_ready <= 0;
    mem_model_inst.mem[2] = 64'h33;
    wr(OFF_CTRL, 32'h3);
    do @(posedge sys_clk); while (!cmd_valid);
    chk(cmd_data, 64'h33);
    wr(OFF_CTRL, 32'h1);
    chk(cmd_valid, 1'b0);
    mem_model_inst.mem[2] = 64'h44; // slot rewritten while queue is disabled
    wr(OFF_CTRL, 32'h3);
    cmd_ready <= 1;
    do @(posedge sys_clk); while (!cmd_valid);
    chk(cmd_data, 64'h44);
  endtask : t_cmdq
  task t_walk;
    mem_model_inst.mem[32] = 64'h0000_0200_0000_0013;
    mem_model_inst.mem[33] = 64'h0000_0200_0000_0012;
    mem_model_inst.mem[65] = 64'hABCD_0001;
    wr(OFF_STREAM_TABLE_BASE, 32'h100);
    wr(OFF_STRTAB_SIZE, 32'h2);
    wr(OFF_CTRL, 32'h0);
    n = mem_model_inst.nrd;
    walk(8'h0, 8'h1, FLT_DISABLED, 64'h0);
    chk(mem_model_inst.nrd, n);
    wr(OFF_CTRL, 32'h1);
    walk(8'h0, 8'h1, FLT_NONE, 64'hABCD_0001);
    walk(8'h0, 8'h2, FLT_RANGE, 64'h0);
    // event queue on, so the next two faults leave records
    wr(OFF_EVTQ_BASE, 32'h80);
    wr(OFF_CTRL, 32'h5);
    n = mem_model_inst.nrd;
    walk(8'h1, 8'h0, FLT_STE, 64'h0);
    chk(mem_model_inst.nrd, n + 1);
    walk(8'h2, 8'h0, FLT_RANGE, 64'h0);
    chk(mem_model_inst.nrd, n + 1);
    repeat (8) @(posedge sys_clk);
    rd(OFF_EVTQ_WRITER, RESP_OKAY);
    chk(d, 32'h2);
    chk(mem_model_inst.mem[16], 64'h2_0100);
    chk(mem_model_inst.mem[17], 64'h1_0200);
    chk(mem_model_inst.ncw, 0);
    wr(OFF_EVTQ_READER, 32'h2);
    rd(OFF_EVTQ_READER, RESP_OKAY);
    chk(d, 32'h2);
  endtask : t_walk
  task t_tlb;
    @(posedge sys_clk);
    {fill_valid, fill_va, fill_pa, fill_block} <= {1'b1, 20'h00200, 20'h00400, 1'b1};
    @(posedge sys_clk);
    {fill_va, fill_pa, fill_block} <= {20'h00203, 20'h00777, 1'b0};
    @(posedge sys_clk);
    fill_valid <= 0;
    look(20'h00203, 1'b1, 20'h00403);
    @(posedge sys_clk);
    {inv_valid, inv_va} <= {1'b1, 20'h00203};
    // lookup right behind the invalidate, no idle cycle between
    @(posedge sys_clk);
    {inv_valid, lookup_valid, lookup_va} <= {1'b0, 1'b1, 20'h00203};
    @(posedge sys_clk);
    lookup_valid <= 0;
    do @(posedge sys_clk); while (!look_done);
    chk(look_hit, 1'b0);
  endtask : t_tlb
  task summarize;
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    rd(OFF_STATUS, RESP_OKAY);
    chk(d, 32'h2);
    rd(8'h40, RESP_DECERR);
    t_cmdq();
    t_walk();
    t_tlb();
    summarize();
  end
  // watchdog sized well past the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule : tb
